//--- rtl/scrs_top.sv
/*
  system clock and reset sequencer: bus clock enables, cpu and
  peripheral clock gating, reset source merging, open-drain reset pin
  drive, reset cause recording and the system counter, with a classic
  wishbone slave for the cause and configuration registers.
  assumes clk_i is the oscillator reference clock at 20 MHz, pll_tick_i
  is a same-clock enable at the pll rate, and the reset pin, power-on,
  low-voltage and watchdog inputs are asynchronous levels.
*/
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`include "scrs_map.svh"
`default_nettype none

// Operation
// - bus rate is reference clock or pll clock divided by four
// - power-on or low-voltage: clocks off 4096 cycles, reset pin low
// - stop exit: counter times recovery, cpu and peripheral clocks off
// - wait mode stops cpu clocks, peripheral clocks keep running
// - every source asserts internal reset; vector fffe, fefe in monitor
// - internal resets clear system counter, external pin reset does not
// - each reset source sets its own cause flag
// - reset aborts instruction, clears only pll_select, selects reference/4
// - pin flag only after minimum low time with no other source
// - internal sources drive pin 32 cycles, then hold reset 32 more
// - recovery 4163 cycles for power-on or low-voltage, else 67
// - power-on: pin low for 4096 + 32, release 32 cycles later
// - power-on asserts reset, enables source clock, sets power flag
// - watchdog overflow resets and flags unless watchdog disabled
// - watchdog request is taken asynchronously to the bus clock
// - illegal opcode resets and flags; stop without enable is illegal
// - only opcode fetch from unmapped address resets and flags
// - low-voltage trip flags and resets unless either disable is set
// - monitor entry with erased vectors resets and flags
// - 12-bit system counter overflow clocks the watchdog
// - stop clears counter; short recovery bit selects 32 not 4096
// - system counter runs freely after every reset state
module scrs_top
  import scrs_pkg::*;
#(
  parameter int POR_RECOVERY_CYC = `SCRS_POR_RECOVERY
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // open-drain reset pin, active low
  input wire logic rst_pin_n_i,
  output logic rst_pin_n_o,
  output logic rst_pin_n_oe_o,
  // asynchronous reset sources
  input wire logic por_pulse_i,
  input wire logic lowvolt_trip_i,
  input wire logic watchdog_ovf_i,
  // cpu status, same clock
  input wire logic bad_opcode_i,
  input wire logic stop_instr_i,
  input wire logic opcode_fetch_i,
  input wire logic unmapped_addr_i,
  input wire logic monitor_entry_i,
  input wire logic monitor_mode_i,
  input wire logic wait_mode_i,
  input wire logic wake_i,
  input wire logic pll_tick_i,
  // clock enables and reset outputs
  output logic source_clk_en_o,
  output logic bus_tick_o,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic internal_reset_o,
  output logic vector_fetch_o,
  output logic [15:0] vector_addr_o,
  // system counter
  output logic [11:0] sys_count_o,
  output logic watchdog_tick_o
);

  localparam int POR_WAIT_CYC = POR_RECOVERY_CYC - `SCRS_RECOVERY_OTHER;
  localparam int VEC_CYC = `SCRS_RECOVERY_OTHER - 2 * `SCRS_ACTIVE_CYC;

  localparam logic [12:0] LIM_POR = 13'(POR_WAIT_CYC);
  localparam logic [12:0] LIM_ACT = 13'(`SCRS_ACTIVE_CYC);
  localparam logic [12:0] LIM_VEC = 13'(VEC_CYC);
  localparam logic [12:0] LIM_SLONG = 13'(`SCRS_STOP_LONG);
  localparam logic [12:0] LIM_SSHORT = 13'(`SCRS_STOP_SHORT);
  localparam logic [12:0] LIM_PIN = 13'(`SCRS_PIN_MIN_CYC);

  // two-stage synchronisers: pin, power-on, low-voltage, watchdog
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] sync3_r;

  scrs_state_t state_r;
  scrs_state_t state_nxt;
  logic [12:0] phase_r;
  logic [12:0] phase_nxt;
  scrs_cause_t cause_r;
  scrs_cause_t cause_set;
  scrs_cfg_t cfg_r;
  logic [1:0] div_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic src_en_r;
  logic [15:0] vec_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // idle levels: pin high, other sources low, so no false hold
      sync1_r <= 4'h1;
      sync2_r <= 4'h1;
      sync3_r <= 4'h1;
    end else begin
      sync1_r <= {watchdog_ovf_i, lowvolt_trip_i, por_pulse_i, rst_pin_n_i};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // synchronised levels and edges
  wire pin_low_w = ~sync2_r[0];
  wire por_lvl_w = sync2_r[1];
  wire por_evt_w = sync2_r[1] & ~sync3_r[1];
  wire lv_en_w = ~(cfg_r.lowvolt_power_disable | cfg_r.lowvolt_reset_disable);
  wire lv_lvl_w = sync2_r[2] & lv_en_w;
  wire lv_evt_w = sync2_r[2] & ~sync3_r[2] & lv_en_w;
  wire wd_evt_w = sync2_r[3] & ~sync3_r[3] & ~cfg_r.watchdog_disable;

  // internal reset sources
  wire in_run_w = (state_r == ST_RUN);
  wire stop_bad_w = stop_instr_i & ~cfg_r.stop_enable;
  wire op_evt_w = in_run_w & (bad_opcode_i | stop_bad_w);
  wire adr_evt_w = in_run_w & opcode_fetch_i & unmapped_addr_i;
  wire mon_evt_w = monitor_entry_i;
  wire hold_w = por_lvl_w | lv_lvl_w;
  wire int_evt_w = wd_evt_w | op_evt_w | adr_evt_w | mon_evt_w;
  wire ext_ok_w = in_run_w | (state_r == ST_STOP) | (state_r == ST_SREC);
  wire ext_evt_w = pin_low_w & ext_ok_w;
  wire stop_go_w = in_run_w & stop_instr_i & cfg_r.stop_enable;

  // phase length of the current state
  wire [12:0] srec_lim_w = cfg_r.short_stop_recovery ? LIM_SSHORT
                                                      : LIM_SLONG;
  wire [12:0] lim_w = (state_r == ST_POR_WAIT) ? LIM_POR :
                      (state_r == ST_VEC) ? LIM_VEC :
                      (state_r == ST_SREC) ? srec_lim_w : LIM_ACT;
  wire done_w = (phase_r == lim_w - 13'h0001);
  wire [12:0] phase_inc_w = phase_r + 13'h0001;

  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_inc_w;
    if (hold_w) begin
      state_nxt = ST_POR_WAIT;
    end else if (int_evt_w && state_r != ST_POR_WAIT) begin
      state_nxt = ST_PIN_LOW;
    end else if (ext_evt_w) begin
      state_nxt = ST_EXT;
    end else begin
      unique case (state_r)
        ST_POR_WAIT: if (done_w) state_nxt = ST_PIN_LOW;
        ST_PIN_LOW: if (done_w) state_nxt = ST_HOLD;
        ST_HOLD: if (done_w) state_nxt = ST_VEC;
        ST_VEC: if (done_w) state_nxt = ST_RUN;
        ST_RUN: if (stop_go_w) state_nxt = ST_STOP;
        ST_STOP: if (wake_i) state_nxt = ST_SREC;
        ST_SREC: if (done_w) state_nxt = ST_RUN;
        ST_EXT: begin
          if (!pin_low_w) begin
            state_nxt = ST_PIN_LOW;
          end else if (phase_r == LIM_PIN) begin
            phase_nxt = phase_r;
          end
        end
      endcase
    end
    // stay at phase zero while the supply or power-on is still low
    if (hold_w || state_nxt != state_r) begin
      phase_nxt = 13'h0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_POR_WAIT;
      phase_r <= 13'h0000;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
    end
  end

  // decoded controls
  wire rst_state_w = (state_r == ST_POR_WAIT) | (state_r == ST_PIN_LOW) |
                     (state_r == ST_HOLD) | (state_r == ST_EXT);
  wire drive_pin_w = (state_r == ST_POR_WAIT) |
                     (state_r == ST_PIN_LOW);

  // counter cleared by internal resets and stop, never by the pin
  wire ctr_clr_w = por_evt_w | lv_evt_w | (state_r == ST_POR_WAIT) |
                   (int_evt_w & ~hold_w) | stop_go_w;

  scrs_ctr u_ctr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(ctr_clr_w),
    .count_o(sys_count_o),
    .ovf_o(watchdog_tick_o)
  );

  // bus clock divider
  wire src_tick_w = cfg_r.pll_select ? pll_tick_i : 1'b1;
  wire bus_tick_w = src_tick_w & (div_r == `SCRS_BUS_DIV_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i || rst_state_w) begin
      div_r <= 2'h0;
    end else if (src_tick_w) begin
      div_r <= div_r + 2'h1;
    end
  end

  // wishbone decode
  wire acc_w = wb_cyc_i & wb_stb_i & ~ack_r;
  wire sel_cause_w = (wb_adr_i == `SCRS_ADR_CAUSE);
  wire sel_cfg_w = (wb_adr_i == `SCRS_ADR_CONFIG);
  wire rd_clr_w = acc_w & ~wb_we_i & sel_cause_w;
  wire cfg_wr_w = acc_w & wb_we_i & sel_cfg_w & wb_sel_i[0];
  wire [31:0] rd_w = sel_cause_w ? {24'h000000, cause_r} :
                     sel_cfg_w ? {24'h000000, cfg_r} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= acc_w;
      if (acc_w) begin
        dat_r <= rd_w;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= `SCRS_CFG_RESET;
    end else if (cfg_wr_w) begin
      cfg_r <= {2'h0, wb_dat_i[5:0]};
    end else if (rst_state_w) begin
      cfg_r.pll_select <= 1'b0;
    end
  end

  // cause flags; a new set wins over the read clear
  wire pin_ok_w = (state_r == ST_EXT) & pin_low_w &
                  (phase_r == LIM_PIN - 13'h0001) &
                  ~hold_w & ~int_evt_w;

  always_comb begin
    cause_set = '0;
    cause_set.por = por_evt_w;
    cause_set.pin = pin_ok_w;
    cause_set.watchdog = wd_evt_w;
    cause_set.bad_opcode_flag = op_evt_w;
    cause_set.bad_address_flag = adr_evt_w;
    cause_set.monitor_entry_reset = mon_evt_w;
    cause_set.low_voltage_reset = lv_evt_w;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_r <= `SCRS_CAUSE_RESET;
    end else if (por_evt_w) begin
      cause_r <= cause_set;
    end else begin
      cause_r <= (cause_r & ~{8{rd_clr_w}}) | cause_set;
    end
  end

  // source clock enable and vector address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_en_r <= 1'b1;
      vec_r <= `SCRS_VEC_NORMAL;
    end else begin
      src_en_r <= 1'b1;
      vec_r <= monitor_mode_i ? `SCRS_VEC_MONITOR
                              : `SCRS_VEC_NORMAL;
    end
  end

  // outputs
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign rst_pin_n_o = 1'b0;
  assign rst_pin_n_oe_o = drive_pin_w;
  assign source_clk_en_o = src_en_r;
  assign bus_tick_o = bus_tick_w & ~rst_state_w;
  assign internal_reset_o = rst_state_w;
  assign vector_fetch_o = (state_r == ST_VEC);
  assign vector_addr_o = vec_r;
  assign cpu_clk_en_o = bus_tick_w & (in_run_w | (state_r == ST_VEC)) &
                        ~wait_mode_i;
  assign periph_clk_en_o = bus_tick_w &
                           (in_run_w | (state_r == ST_VEC));

endmodule : scrs_top

`default_nettype wire

//--- rtl/scrs_map.svh
/*
  constants of the system clock and reset sequencer: register offsets,
  reset values, vector addresses and cycle counts.
  assumes it is included by bare name by scrs_top and scrs_ctr.
*/
`ifndef SCRS_MAP_SVH
`define SCRS_MAP_SVH

// register byte offsets on the wishbone slave
`define SCRS_ADR_CAUSE 4'h0
`define SCRS_ADR_CONFIG 4'h4

// reset values
`define SCRS_CAUSE_RESET 8'h80
`define SCRS_CFG_RESET 8'h00

// reset vector addresses
`define SCRS_VEC_NORMAL 16'hfffe
`define SCRS_VEC_MONITOR 16'hfefe

// bus clock divides its source by four: divider counts 0..3
`define SCRS_BUS_DIV_LAST 2'h3

// cycle counts, in oscillator reference clock cycles
`define SCRS_POR_RECOVERY 4163
`define SCRS_RECOVERY_OTHER 67
`define SCRS_ACTIVE_CYC 32
`define SCRS_STOP_LONG 4096
`define SCRS_STOP_SHORT 32
`define SCRS_PIN_MIN_CYC 4

// system counter
`define SCRS_CTR_MAX 12'hfff

`endif

//--- rtl/scrs_pkg.sv
/*
  types of the system clock and reset sequencer: sequencer states,
  reset cause flags and configuration bits.
  assumes scrs_map.svh is on the include path.
*/
`default_nettype none

package scrs_pkg;

  // gray codes along power-on, pin low, hold, vector, run, stop, recover
  typedef enum logic [2:0] {
    ST_POR_WAIT = 3'h0,
    ST_PIN_LOW = 3'h1,
    ST_HOLD = 3'h3,
    ST_VEC = 3'h2,
    ST_RUN = 3'h6,
    ST_STOP = 3'h7,
    ST_SREC = 3'h5,
    ST_EXT = 3'h4
  } scrs_state_t;

  // reset_cause_register layout, bit 7 down to bit 0
  typedef struct packed {
    logic por;
    logic pin;
    logic watchdog;
    logic bad_opcode_flag;
    logic bad_address_flag;
    logic monitor_entry_reset;
    logic low_voltage_reset;
    logic zero;
  } scrs_cause_t;

  // config_reg_one layout, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] rsvd;
    logic pll_select;
    logic short_stop_recovery;
    logic lowvolt_power_disable;
    logic lowvolt_reset_disable;
    logic stop_enable;
    logic watchdog_disable;
  } scrs_cfg_t;

endpackage : scrs_pkg

`default_nettype wire

//--- rtl/scrs_ctr.sv
/*
  12-bit free-running system counter with synchronous clear and a
  one-cycle overflow pulse that prescales the watchdog timer.
  assumes clear comes from logic on the same clock.
*/
`include "scrs_map.svh"
`default_nettype none

module scrs_ctr
  import scrs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic clr_i,
  // counter state
  output logic [11:0] count_o,
  output logic ovf_o
);

  logic [11:0] count_r;
  logic ovf_r;
  wire wrap_w = (count_r == `SCRS_CTR_MAX);

  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      count_r <= 12'h000;
      ovf_r <= 1'b0;
    end else begin
      count_r <= count_r + 12'h001;
      ovf_r <= wrap_w;
    end
  end

  assign count_o = count_r;
  assign ovf_o = ovf_r;

endmodule : scrs_ctr

`default_nettype wire

//--- testbench/scrs_asserts.sv
/*
  port assertions for the clock and reset sequencer.
  assumes it is bound into scrs_top, one clock domain.
*/
`default_nettype none
module scrs_asserts
  import scrs_pkg::*;
#(
  parameter int POR_RECOVERY_CYC = 4163
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // sequencing
  input wire logic rst_pin_n_oe_o,
  input wire logic monitor_mode_i,
  input wire logic wait_mode_i,
  input wire logic bus_tick_o,
  input wire logic cpu_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic internal_reset_o,
  input wire logic vector_fetch_o,
  input wire logic [15:0] vector_addr_o,
  input wire logic [11:0] sys_count_o,
  input wire logic watchdog_tick_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_after_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o && wb_dat_o[31:8] == 0)
    else $error("ack late or upper data set");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_clk_off_reset: assert property (
    internal_reset_o |-> !bus_tick_o && !periph_clk_en_o)
    else $error("clock tick during reset");
  a_cpu_wait_gate: assert property (
    cpu_clk_en_o |-> periph_clk_en_o && !wait_mode_i)
    else $error("cpu clock in wait");
  a_bus_div_four: assert property (bus_tick_o |=> !bus_tick_o [*3])
    else $error("bus tick faster than quarter rate");
  a_pin_then_hold: assert property (
    $fell(rst_pin_n_oe_o) |-> internal_reset_o ##32 vector_fetch_o)
    else $error("hold phase not 32 cycles");
  a_vec_three: assert property (
    $rose(vector_fetch_o) |-> vector_fetch_o [*3] ##1 !vector_fetch_o)
    else $error("vector phase not 3 cycles");
  a_vec_address: assert property (
    vector_fetch_o |->
      vector_addr_o == ($past(monitor_mode_i) ? 16'hfefe : 16'hfffe))
    else $error("wrong vector address");
  a_wd_overflow: assert property (
    sys_count_o == 12'hfff |=> watchdog_tick_o)
    else $error("no watchdog tick on overflow");
endmodule : scrs_asserts

bind scrs_top scrs_asserts #(.POR_RECOVERY_CYC(POR_RECOVERY_CYC)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .rst_pin_n_oe_o(rst_pin_n_oe_o), .monitor_mode_i(monitor_mode_i),
  .wait_mode_i(wait_mode_i), .bus_tick_o(bus_tick_o),
  .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
  .internal_reset_o(internal_reset_o), .vector_fetch_o(vector_fetch_o),
  .vector_addr_o(vector_addr_o), .sys_count_o(sys_count_o),
  .watchdog_tick_o(watchdog_tick_o));
`default_nettype wire

//--- testbench/scrs_pin_model.sv
/*
  board side of the reset pin: pullup and an external switch.
  assumes the sequencer only ever drives the pin low.
*/
`default_nettype none
module scrs_pin_model (
  // drivers
  input wire logic pull_i,
  input wire logic drv_i,
  input wire logic oe_i,
  // resolved level
  output logic pin_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // pullup unless someone pulls low
  assign pin_n_o = (pull_i || (oe_i && !drv_i)) ? 1'b0 : 1'b1;
endmodule : scrs_pin_model
`default_nettype wire

//--- testbench/tb_scrs_top.sv
/*
  self-checking bench for scrs_top: power-on, internal and pin resets,
  low voltage, stop, wait and bus rate.
  assumes a 50 ns clock and a pulled-up reset pin.
*/
`default_nettype none
module tb_scrs_top
  import scrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POR_CYC = 99;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h1;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic [4:0] ev = 5'h00;
  logic por = 1'b0, lv = 1'b0, unm = 1'b0, mon = 1'b0, wt = 1'b0;
  logic wake = 1'b0, pll = 1'b0, pull = 1'b0;
  logic ack, pin_w, drv, oe, src_en, btick, cpu_en, per_en, internal_reset, vf_o, wdt;
  logic [15:0] va, vaddr;
  logic [11:0] cnt;
  int errors = 0, samples_checked = 0, pl, ir, nv;

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) pll <= ~pll;

  scrs_pin_model pin_u (.pull_i(pull), .drv_i(drv), .oe_i(oe),
    .pin_n_o(pin_w));
  scrs_top #(.POR_RECOVERY_CYC(POR_CYC)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .rst_pin_n_i(pin_w),
    .rst_pin_n_o(drv), .rst_pin_n_oe_o(oe), .por_pulse_i(por),
    .lowvolt_trip_i(lv), .watchdog_ovf_i(ev[0]), .bad_opcode_i(ev[1]),
    .stop_instr_i(ev[2]), .opcode_fetch_i(ev[3]), .unmapped_addr_i(unm),
    .monitor_entry_i(ev[4]), .monitor_mode_i(mon), .wait_mode_i(wt),
    .wake_i(wake), .pll_tick_i(pll), .source_clk_en_o(src_en),
    .bus_tick_o(btick), .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en),
    .internal_reset_o(internal_reset), .vector_fetch_o(vf_o), .vector_addr_o(va),
    .sys_count_o(cnt), .watchdog_tick_o(wdt));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic ok(input logic c);
    check({31'h0, c}, 32'h1);
  endtask : ok

  task automatic report_and_stop;
    $display("compares=%0d mismatches=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    // no cycle count assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask : wb

  // counts pin-low, reset and vector cycles until the vector ends
  task automatic seq;
    pl = 0;
    ir = 0;
    nv = 0;
    for (int n = 0; n < 6000; n++) begin
      @(posedge clk_i);
      if (pin_w === 1'b0) pl++;
      if (internal_reset === 1'b1) ir++;
      if (vf_o === 1'b1) vaddr = va;
      if (vf_o === 1'b1) nv++;
      if (nv > 0 && vf_o !== 1'b1) break;
    end
  endtask : seq

  task automatic t_por;
    seq();
    check(pl, POR_CYC - 35);
    check(ir, POR_CYC - 3);
    ok(src_en === 1'b1);
    wb(1'b0, 4'h0, 32'h0);
    check(rd, 32'h80);
    $display("power-on done");
  endtask : t_por

  task automatic t_clocks;
    int c, p, b;
    c = 0;
    p = 0;
    b = 0;
    wt <= 1'b1;
    repeat (40) begin
      @(posedge clk_i);
      if (cpu_en === 1'b1) c++;
      if (per_en === 1'b1) p++;
      if (btick === 1'b1) b++;
    end
    wt <= 1'b0;
    check(c, 32'h0);
    check(p, 32'ha);
    check(b, 32'ha);
    wb(1'b1, 4'h4, 32'h20);
    b = 0;
    c = 0;
    repeat (40) begin
      @(posedge clk_i);
      if (cpu_en === 1'b1) c++;
      if (btick === 1'b1) b++;
    end
    check(b, 32'h5);
    check(c, 32'h5);
    ev <= 5'h02;
    @(posedge clk_i);
    ev <= 5'h00;
    seq();
    wb(1'b0, 4'h4, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, 4'h0, 32'h0);
    $display("clocks done");
  endtask : t_clocks

  task automatic t_internal;
    logic [7:0] flag [5] = '{8'h20, 8'h10, 8'h10, 8'h08, 8'h04};
    wb(1'b1, 4'h4, 32'h1);
    {ev, unm} <= 6'h03;
    @(posedge clk_i);
    {ev, unm} <= 6'h00;
    repeat (6) @(posedge clk_i);
    ok(internal_reset !== 1'b1);
    wb(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, 4'h4, 32'h0);
    for (int i = 0; i < 5; i++) begin
      ev <= 5'h01 << i;
      unm <= (i == 3);
      mon <= (i == 4);
      @(posedge clk_i);
      ev <= 5'h00;
      seq();
      check(pl, 32'h20);
      check(ir, 32'h40);
      check({16'h0, vaddr}, (i == 4) ? 32'hfefe : 32'hfffe);
      ok(cnt < 12'h50);
      wb(1'b0, 4'h0, 32'h0);
      check(rd, {24'h0, flag[i]});
    end
    mon <= 1'b0;
    $display("internal sources done");
  endtask : t_internal

  task automatic t_pin;
    for (int n = 0; n < 5000 && cnt < 12'h400; n++) @(posedge clk_i);
    pull <= 1'b1;
    repeat (8) @(posedge clk_i);
    pull <= 1'b0;
    seq();
    ok(ir >= 64);
    ok(cnt >= 12'h400);
    wb(1'b0, 4'h0, 32'h0);
    check(rd, 32'h40);
    $display("pin reset done");
  endtask : t_pin

  task automatic t_lowvolt;
    logic [7:0] dis [4] = '{8'h0c, 8'h04, 8'h08, 8'h00};
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, 4'h4, {24'h0, dis[k]});
      lv <= 1'b1;
      repeat (6) @(posedge clk_i);
      lv <= 1'b0;
      ok(internal_reset === (k == 3));
    end
    seq();
    // two synchroniser cycles after the drop, then wait and pin phases
    check(pl, POR_CYC - 33);
    check(ir, POR_CYC - 1);
    wb(1'b0, 4'h0, 32'h0);
    check(rd, 32'h2);
    $display("low voltage done");
  endtask : t_lowvolt

  task automatic t_power;
    por <= 1'b1;
    repeat (6) @(posedge clk_i);
    por <= 1'b0;
    ok(internal_reset === 1'b1);
    seq();
    check(pl, POR_CYC - 33);
    check(ir, POR_CYC - 1);
    ok(cnt < 12'h50);
    wb(1'b0, 4'h0, 32'h0);
    check(rd, 32'h80);
    $display("power-on pulse done");
  endtask : t_power

  task automatic t_stop;
    int n;
    logic [7:0] cf [2] = '{8'h12, 8'h02};
    int rec [2] = '{32, 4096};
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, 4'h4, {24'h0, cf[k]});
      ev <= 5'h04;
      @(posedge clk_i);
      ev <= 5'h00;
      repeat (6) @(posedge clk_i);
      ok(cnt < 12'h8);
      wake <= 1'b1;
      @(posedge clk_i);
      wake <= 1'b0;
      n = 0;
      while (per_en !== 1'b1 && n < 5000) begin
        @(posedge clk_i);
        n++;
      end
      ok(n >= rec[k] && n <= rec[k] + 8);
    end
    wb(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0);
    $display("stop done");
  endtask : t_stop

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_por();
    t_clocks();
    t_internal();
    t_pin();
    t_lowvolt();
    t_power();
    t_stop();
    report_and_stop();
  end

  initial begin
    #1000000;
    errors++;
    report_and_stop();
  end
endmodule : tb_scrs_top
`default_nettype wire
